// File: bench/drm_host_model.sv
// host processor model: register port transfers and data streaming
`timescale 1ns/10ps
`default_nettype none
module drm_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [drm_pkg::ADDR_W-1:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    import drm_pkg::*;
    logic dummy_due = 1'b1;
    initial begin
        addr_out = '0;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        // released bus shows junk, never the last byte
        wdata_out <= ~d;
        if (a <= REG_COL) begin
            dummy_due = 1'b1;
        end
    endtask : wr_reg
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        // read data stand in the cycle after the strobe; taken at its closing edge
        @(posedge clk_in);
        d = rdata_in;
    endtask : rd_reg
    task automatic seek(input logic [7:0] page, input logic [7:0] col);
        wr_reg(REG_PAGE, page);
        wr_reg(REG_COL, col);
    endtask : seek
    task automatic set_start(input logic [7:0] line);
        wr_reg(REG_START, line & START_MASK);
    endtask : set_start
    // holder returns the previous fetch, so one discarded read first
    task automatic rd_data(output logic [7:0] d);
        if (dummy_due) begin
            rd_reg(REG_DATA, d);
        end
        dummy_due = 1'b0;
        rd_reg(REG_DATA, d);
    endtask : rd_data
endmodule : drm_host_model
`default_nettype wire

// File: bench/drm_monitor.sv
// port-level checks for the display ram mapper
`timescale 1ns/10ps
`default_nettype none
module drm_monitor (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [drm_pkg::ADDR_W-1:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic serial_mode_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic pix_valid_out,
    input wire logic [7:0] segment_output_out,
    input wire logic [7:0] common_output_out,
    input wire logic [1:0] level_out,
    input wire logic dark_out,
    input wire logic [drm_pkg::FRAME_W-1:0] frame_out
);
    import drm_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_pix_spacing: assert property (pix_valid_out |=> !pix_valid_out [*3] ##1 pix_valid_out)
        else $error("panel dot pulses not every fourth clock");
    a_seg_range: assert property (pix_valid_out |-> segment_output_out <= LAST_COL)
        else $error("segment index beyond last column");
    a_com_range: assert property (pix_valid_out |-> common_output_out <= LAST_LINE)
        else $error("common index beyond last line");
    a_seg_step: assert property ((pix_valid_out && segment_output_out != 8'hB3) |->
        ##4 (segment_output_out == $past(segment_output_out, 4) + 8'h01))
        else $error("segment index did not step by one");
    a_seg_wrap: assert property ((pix_valid_out && segment_output_out == 8'hB3) |->
        ##4 (segment_output_out == 8'h00))
        else $error("segment index did not wrap to zero");
    a_com_hold: assert property ((pix_valid_out && segment_output_out != 8'hB3) |->
        ##4 (common_output_out == $past(common_output_out, 4)))
        else $error("common index moved inside a line");
    // frame_out is not latched: it steps together with the last dot of a frame
    a_frame_hold: assert property ((pix_valid_out && segment_output_out != 8'hB2) |->
        ##4 (frame_out == $past(frame_out, 4)))
        else $error("frame counter moved inside a line");
    a_rdata_hold: assert property ($stable(host_rdata_out) || $past(host_rd_in))
        else $error("read data changed without a read");
    // serial level held three edges so the synchroniser has caught up
    a_rd_serial: assert property ((host_rd_in && host_addr_in == REG_DATA && serial_mode_in
        && $past(serial_mode_in) && $past(serial_mode_in, 2)) |=> host_rdata_out == 8'h00)
        else $error("memory read returned data in serial mode");
    a_stat_serial: assert property ((host_rd_in && host_addr_in == REG_STATUS && serial_mode_in
        && $past(serial_mode_in) && $past(serial_mode_in, 2)) |=> host_rdata_out[STAT_SERIAL])
        else $error("status did not show serial port");
endmodule : drm_monitor
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the display ram mapper
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import drm_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic serial_mode_in = 1'b0;
    logic [ADDR_W-1:0] host_addr_in;
    logic [7:0] host_wdata_in;
    logic host_wr_in;
    logic host_rd_in;
    logic [7:0] host_rdata_out;
    logic pix_valid_out;
    logic [7:0] segment_output_out;
    logic [7:0] common_output_out;
    logic [1:0] level_out;
    logic dark_out;
    logic [FRAME_W-1:0] frame_out;
    int n_tests = 0;
    int bad_count = 0;
    // stepping cases: mode, start page/column, expected next page/column
    logic [7:0] t_mode [4] = '{8'h00, 8'h02, 8'h00, 8'h02};
    logic [7:0] t_page [4] = '{8'h00, 8'h20, 8'h20, 8'h20};
    logic [7:0] t_col [4] = '{8'hB3, 8'h05, 8'hB3, 8'hB3};
    logic [7:0] t_npage [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] t_ncol [4] = '{8'h00, 8'h06, 8'h00, 8'h00};
    // panel cases: all-on, all-on inverted, blanked
    logic [7:0] p_mode [3] = '{8'h60, 8'h70, 8'h40};
    logic [7:0] p_level [3] = '{8'h03, 8'h00, 8'h00};
    logic [7:0] p_dark [3] = '{8'h01, 8'h00, 8'h00};
    // four-level byte 8'h1B: pairs 11, 10, 01, 00 from the lowest line up
    logic [7:0] g_level [4] = '{8'h03, 8'h02, 8'h01, 8'h00};
    logic [7:0] g_dark [4] = '{8'h01, 8'h01, 8'h00, 8'h00};

    always #5 clk_in = ~clk_in;

    drm_top drm_top_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .host_addr_in(host_addr_in),
        .host_wdata_in(host_wdata_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
        .serial_mode_in(serial_mode_in), .host_rdata_out(host_rdata_out),
        .pix_valid_out(pix_valid_out), .segment_output_out(segment_output_out),
        .common_output_out(common_output_out), .level_out(level_out),
        .dark_out(dark_out), .frame_out(frame_out)
    );
    drm_host_model drm_host_model_inst (
        .clk_in(clk_in), .rdata_in(host_rdata_out), .addr_out(host_addr_in),
        .wdata_out(host_wdata_in), .wr_out(host_wr_in), .rd_out(host_rd_in)
    );

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check8
    // next latched dot, or the next one at a given segment and common
    task automatic wait_dot(input logic [7:0] s, input logic [7:0] c, input logic any_dot);
        logic found;
        found = 1'b0;
        for (int k = 0; k < 4000 && !found; k++) begin
            @(posedge clk_in);
            #1;
            found = pix_valid_out === 1'b1 && (any_dot || (segment_output_out === s
                && common_output_out === c));
        end
        if (!found) begin
            bad_count++;
            $display("Error dot wait expected seg %h com %h seen none", s, c);
        end
    endtask : wait_dot
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        logic [7:0] d;
        logic [FRAME_W-1:0] f;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        drm_host_model_inst.rd_reg(REG_STATUS, d);
        check8("status after reset", 8'h00, d);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            drm_host_model_inst.wr_reg(REG_MODE, t_mode[i]);
            drm_host_model_inst.seek(t_page[i], t_col[i]);
            drm_host_model_inst.wr_reg(REG_DATA, 8'(8'hA0 + i));
            drm_host_model_inst.wr_reg(REG_DATA, 8'(8'h50 + i));
            drm_host_model_inst.seek(t_page[i], t_col[i]);
            drm_host_model_inst.rd_data(d);
            check8("first byte", 8'(8'hA0 + i), d);
            drm_host_model_inst.rd_data(d);
            check8("stepped byte", 8'(8'h50 + i), d);
            drm_host_model_inst.seek(t_npage[i], t_ncol[i]);
            drm_host_model_inst.rd_data(d);
            check8("byte at next place", 8'(8'h50 + i), d);
        end
        $display("test pointer stepping done");
        serial_mode_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        drm_host_model_inst.rd_reg(REG_DATA, d);
        check8("serial data read", 8'h00, d);
        drm_host_model_inst.rd_reg(REG_STATUS, d);
        check8("serial status", 8'h82, d);
        serial_mode_in <= 1'b0;
        $display("test serial port done");
        drm_host_model_inst.set_start(8'h13);
        // long enough for a full line so segment wrap is seen
        repeat (800) @(posedge clk_in);
        for (int i = 0; i < 3; i++) begin
            drm_host_model_inst.wr_reg(REG_MODE, p_mode[i]);
            repeat (3) wait_dot(8'h00, 8'h00, 1'b1);
            check8("panel level", p_level[i], {6'h00, level_out});
            check8("panel dark", p_dark[i], {7'h00, dark_out});
        end
        $display("test output latch done");
        // four lines a frame keeps every wait under one frame
        drm_host_model_inst.wr_reg(REG_LINES, 8'h04);
        drm_host_model_inst.wr_reg(REG_GRAY, 8'h80);
        drm_host_model_inst.seek(8'h04, 8'h02);
        drm_host_model_inst.wr_reg(REG_DATA, 8'h1B);
        drm_host_model_inst.seek(8'h02, 8'h02);
        drm_host_model_inst.wr_reg(REG_DATA, 8'h01);
        drm_host_model_inst.wr_reg(REG_MODE, 8'h21);
        for (int k = 0; k < 4; k++) begin
            wait_dot(8'h02, 8'(k), 1'b0);
            check8("gray level", g_level[k], {6'h00, level_out});
            check8("gray dark", g_dark[k], {7'h00, dark_out});
        end
        wait_dot(8'hB3, 8'h03, 1'b0);
        f = FRAME_W'(frame_out + 1'b1);
        wait_dot(8'hB3, 8'h03, 1'b0);
        check8("frame count", 8'(f), 8'(frame_out));
        drm_host_model_inst.wr_reg(REG_MODE, 8'h25);
        wait_dot(8'hB1, 8'h00, 1'b0);
        check8("reversed column level", 8'h03, {6'h00, level_out});
        drm_host_model_inst.wr_reg(REG_MODE, 8'h20);
        wait_dot(8'h02, 8'h00, 1'b0);
        check8("two-level one", 8'h03, {6'h00, level_out});
        wait_dot(8'h02, 8'h01, 1'b0);
        check8("two-level zero", 8'h00, {6'h00, level_out});
        // switched at a line end so the common index never jumps inside a line
        wait_dot(8'hB3, 8'h01, 1'b0);
        drm_host_model_inst.wr_reg(REG_MODE, 8'h29);
        wait_dot(8'h02, 8'h83, 1'b0);
        check8("reversed common level", 8'h03, {6'h00, level_out});
        $display("test panel content done");
        stop_test();
    end

    initial begin
        repeat (40000) @(posedge clk_in);
        bad_count++;
        $display("Error watchdog expected finish seen hang");
        stop_test();
    end
endmodule : testbench

bind drm_top drm_monitor drm_monitor_inst (
    .clk_in, .rst_n_in, .host_addr_in, .host_wdata_in, .host_wr_in, .host_rd_in,
    .serial_mode_in, .host_rdata_out, .pix_valid_out, .segment_output_out,
    .common_output_out, .level_out, .dark_out, .frame_out
);
`default_nettype wire

// File: hdl/drm_out_latch.sv
// output latch: dot level, frame modulation, inversion and blanking
`timescale 1ns/10ps
`default_nettype none
module drm_out_latch (
    input wire logic clk_in,
    input wire logic rst_n_in,
    drm_pix_if.latch pix
);
    import drm_pkg::*;

    logic valid_reg, valid_next;
    logic [7:0] seg_reg, seg_next;
    logic [7:0] com_reg, com_next;
    logic [1:0] level_reg, level_next;
    logic dark_reg, dark_next;

    function automatic logic [3:0] clamp_pat(input logic [3:0] p);
        clamp_pat = (p > GRAY_MAX) ? GRAY_MAX : p;
    endfunction : clamp_pat

    always_comb begin
        logic [1:0] lvl;
        logic on;
        lvl = DOT_WHITE;
        on = 1'b0;
        valid_next = pix.pix_valid;
        seg_next = seg_reg;
        com_next = com_reg;
        level_next = level_reg;
        dark_next = dark_reg;
        if (pix.pix_valid) begin
            // two-level: one bit per dot, one shows black
            lvl = pix.gray_mode ? pix.raw_dot : (pix.raw_dot[0] ? DOT_BLACK : DOT_WHITE);
            // mid levels lit on a share of an eight-frame cycle: nine densities
            unique case (lvl)
                DOT_BLACK: on = 1'b1;
                DOT_MID2: on = {1'b0, pix.frame} < clamp_pat(pix.pat2);
                DOT_MID1: on = {1'b0, pix.frame} < clamp_pat(pix.pat1);
                DOT_WHITE: on = 1'b0;
            endcase
            // memory is untouched, only the latched copy is altered
            if (pix.all_on) begin
                on = 1'b1;
                lvl = DOT_BLACK;
            end
            if (pix.invert) begin
                on = ~on;
                lvl = ~lvl;
            end
            if (!pix.disp_on) begin
                on = 1'b0;
                lvl = DOT_WHITE;
            end
            seg_next = pix.seg_idx;
            com_next = pix.com_idx;
            level_next = lvl;
            dark_next = on;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            valid_reg <= 1'b0;
            seg_reg <= 8'h00;
            com_reg <= 8'h00;
            level_reg <= DOT_WHITE;
            dark_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
            seg_reg <= seg_next;
            com_reg <= com_next;
            level_reg <= level_next;
            dark_reg <= dark_next;
        end
    end

    assign pix.lat_valid = valid_reg;
    assign pix.lat_seg = seg_reg;
    assign pix.lat_com = com_reg;
    assign pix.lat_level = level_reg;
    assign pix.lat_dark = dark_reg;
endmodule : drm_out_latch
`default_nettype wire

// File: hdl/drm_pix_if.sv
// carrier between the scan path and the output latch
`timescale 1ns/10ps
`default_nettype none
interface drm_pix_if;
    import drm_pkg::*;
    logic pix_valid;
    logic [1:0] raw_dot;
    logic [7:0] seg_idx;
    logic [7:0] com_idx;
    logic [FRAME_W-1:0] frame;
    logic gray_mode;
    logic invert;
    logic disp_on;
    logic all_on;
    logic [3:0] pat1;
    logic [3:0] pat2;
    logic lat_valid;
    logic [7:0] lat_seg;
    logic [7:0] lat_com;
    logic [1:0] lat_level;
    logic lat_dark;
    modport src (
        output pix_valid, raw_dot, seg_idx, com_idx, frame, gray_mode, invert, disp_on,
        output all_on, pat1, pat2,
        input lat_valid, lat_seg, lat_com, lat_level, lat_dark
    );
    modport latch (
        input pix_valid, raw_dot, seg_idx, com_idx, frame, gray_mode, invert, disp_on,
        input all_on, pat1, pat2,
        output lat_valid, lat_seg, lat_com, lat_level, lat_dark
    );
endinterface : drm_pix_if
`default_nettype wire

// File: hdl/drm_pkg.sv
// constants shared by the display ram mapper
package drm_pkg;
    localparam int NUM_COLS = 180;
    localparam int NUM_LINES = 132;
    localparam int NUM_PAGES = 33;
    localparam int MEM_DEPTH = NUM_PAGES * NUM_COLS;
    localparam int IDX_W = 13;
    localparam int ADDR_W = 3;
    localparam logic [7:0] LAST_COL = 8'hB3;
    localparam logic [5:0] LAST_PAGE = 6'h20;
    localparam logic [7:0] LAST_LINE = 8'h83;
    localparam logic [7:0] LINE_COUNT = 8'h84;
    localparam logic [7:0] TOP_START = 8'h80;
    localparam logic [8:0] LINE_WRAP = 9'h084;
    // host port addresses
    localparam logic [ADDR_W-1:0] REG_DATA = 3'h0;
    localparam logic [ADDR_W-1:0] REG_PAGE = 3'h1;
    localparam logic [ADDR_W-1:0] REG_COL = 3'h2;
    localparam logic [ADDR_W-1:0] REG_START = 3'h3;
    localparam logic [ADDR_W-1:0] REG_MODE = 3'h4;
    localparam logic [ADDR_W-1:0] REG_LINES = 3'h5;
    localparam logic [ADDR_W-1:0] REG_GRAY = 3'h6;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h7;
    // mode register fields
    localparam int MODE_GRAY = 0;
    localparam int MODE_PAGE_STEP = 1;
    localparam int MODE_COL_REV = 2;
    localparam int MODE_COM_REV = 3;
    localparam int MODE_INVERT = 4;
    localparam int MODE_DISP_ON = 5;
    localparam int MODE_ALL_ON = 6;
    localparam int STAT_SERIAL = 7;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_MASK = 8'h7F;
    localparam logic [7:0] GRAY_RESET = 8'h63;
    localparam logic [3:0] GRAY_MAX = 4'h8;
    localparam logic [7:0] START_MASK = 8'hFC;
    localparam logic [1:0] DOT_BLACK = 2'h3;
    localparam logic [1:0] DOT_MID2 = 2'h2;
    localparam logic [1:0] DOT_MID1 = 2'h1;
    localparam logic [1:0] DOT_WHITE = 2'h0;
    localparam int FRAME_W = 3;
    // panel scan runs one dot per this many system clocks
    localparam logic [7:0] SCAN_DIV = 8'h04;
endpackage : drm_pkg

// File: hdl/drm_top.sv
// display memory, host pointers and panel scan for a dot-matrix driver
`timescale 1ns/10ps
`default_nettype none
module drm_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [drm_pkg::ADDR_W-1:0] host_addr_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic serial_mode_in,
    output logic [7:0] host_rdata_out,
    output logic pix_valid_out,
    output logic [7:0] segment_output_out,
    output logic [7:0] common_output_out,
    output logic [1:0] level_out,
    output logic dark_out,
    output logic [drm_pkg::FRAME_W-1:0] frame_out
);
    import drm_pkg::*;

    // serial select is a pin: two flops before use
    logic ser_meta_reg;
    logic ser_reg;

    logic [5:0] page_reg, page_next;
    logic [7:0] col_reg, col_next;
    logic [7:0] start_reg, start_next;
    logic [7:0] mode_reg, mode_next;
    logic [7:0] lines_reg, lines_next;
    logic [7:0] gray_reg, gray_next;
    logic [7:0] holder_reg, holder_next;
    logic [7:0] rdata_reg, rdata_next;

    logic [7:0] mem [0:MEM_DEPTH-1];
    logic mem_we;
    logic [IDX_W-1:0] host_idx;

    logic [7:0] div_reg, div_next;
    logic [7:0] sseg_reg, sseg_next;
    logic [7:0] sline_reg, sline_next;
    logic [FRAME_W-1:0] frame_reg, frame_next;
    logic tick;

    logic [8:0] line_sum;
    logic [7:0] disp_line;
    logic [7:0] disp_col;
    logic [IDX_W-1:0] disp_idx;

    drm_pix_if pix ();

    function automatic logic [IDX_W-1:0] mem_index(input logic [5:0] page,
                                                   input logic [7:0] col);
        mem_index = IDX_W'(int'(page) * NUM_COLS + int'(col));
    endfunction : mem_index

    // gray: four lines per page; two-level: eight lines per page
    function automatic logic [5:0] page_of(input logic [7:0] line, input logic gray);
        page_of = gray ? line[7:2] : {1'b0, line[7:3]};
    endfunction : page_of

    function automatic logic [1:0] dot_of(input logic [7:0] data, input logic [7:0] line,
                                          input logic gray);
        logic [1:0] d;
        d = 2'b00;
        if (gray) begin
            // low pair is the lowest line; upper bit of the pair is the msb
            unique case (line[1:0])
                2'h0: d = {data[1], data[0]};
                2'h1: d = {data[3], data[2]};
                2'h2: d = {data[5], data[4]};
                2'h3: d = {data[7], data[6]};
            endcase
        end else begin
            d = {1'b0, data[line[2:0]]};
        end
        dot_of = d;
    endfunction : dot_of

    // host pointer clamps keep the index inside the array
    function automatic logic [5:0] clamp_page(input logic [7:0] v);
        clamp_page = (v > {2'b00, LAST_PAGE}) ? LAST_PAGE : v[5:0];
    endfunction : clamp_page

    function automatic logic [7:0] clamp_col(input logic [7:0] v);
        clamp_col = (v > LAST_COL) ? LAST_COL : v;
    endfunction : clamp_col

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ser_meta_reg <= 1'b0;
            ser_reg <= 1'b0;
        end else begin
            ser_meta_reg <= serial_mode_in;
            ser_reg <= ser_meta_reg;
        end
    end

    assign host_idx = mem_index(page_reg, col_reg);

    // host side: pointers, settings, holder and read data
    always_comb begin
        logic access;
        access = 1'b0;
        page_next = page_reg;
        col_next = col_reg;
        start_next = start_reg;
        mode_next = mode_reg;
        lines_next = lines_reg;
        gray_next = gray_reg;
        holder_next = holder_reg;
        rdata_next = rdata_reg;
        mem_we = 1'b0;
        if (host_wr_in) begin
            unique case (host_addr_in)
                REG_DATA: begin
                    mem_we = 1'b1;
                    access = 1'b1;
                end
                REG_PAGE: page_next = clamp_page(host_wdata_in);
                REG_COL: col_next = clamp_col(host_wdata_in);
                REG_START: begin
                    // takes effect on the next scanned dot, even inside a line: scrolling is live
                    start_next = host_wdata_in & START_MASK;
                    if (start_next > LAST_LINE) begin
                        start_next = TOP_START;
                    end
                end
                REG_MODE: mode_next = host_wdata_in & MODE_MASK;
                REG_LINES: begin
                    lines_next = host_wdata_in;
                    if (lines_next == 8'h00 || lines_next > LINE_COUNT) begin
                        lines_next = LINE_COUNT;
                    end
                end
                REG_GRAY: gray_next = host_wdata_in;
                REG_STATUS: ;
            endcase
        end else if (host_rd_in) begin
            if (host_addr_in == REG_STATUS) begin
                rdata_next = {ser_reg, mode_reg[6:0]};
            end else if (host_addr_in == REG_DATA && !ser_reg) begin
                // pipeline: old holder goes out, current cell is fetched
                rdata_next = holder_reg;
                holder_next = mem[host_idx];
                access = 1'b1;
            end else if (host_addr_in == REG_DATA) begin
                rdata_next = 8'h00;
            end else begin
                rdata_next = 8'h00;
            end
        end
        if (access) begin
            if (mode_reg[MODE_PAGE_STEP]) begin
                page_next = page_reg + 6'h01;
                if (page_reg == LAST_PAGE) begin
                    page_next = 6'h00;
                    col_next = (col_reg == LAST_COL) ? 8'h00 : col_reg + 8'h01;
                end
            end else begin
                col_next = col_reg + 8'h01;
                if (col_reg == LAST_COL) begin
                    col_next = 8'h00;
                    page_next = (page_reg == LAST_PAGE) ? 6'h00 : page_reg + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            page_reg <= 6'h00;
            col_reg <= 8'h00;
            start_reg <= 8'h00;
            mode_reg <= MODE_RESET;
            lines_reg <= LINE_COUNT;
            gray_reg <= GRAY_RESET;
            holder_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            page_reg <= page_next;
            col_reg <= col_next;
            start_reg <= start_next;
            mode_reg <= mode_next;
            lines_reg <= lines_next;
            gray_reg <= gray_next;
            holder_reg <= holder_next;
            rdata_reg <= rdata_next;
        end
    end

    // memory contents are not reset; only the host port writes them
    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[host_idx] <= host_wdata_in;
        end
    end

    // panel scan: own counters and own read port, never shared with the host
    always_comb begin
        tick = (div_reg == SCAN_DIV - 8'h01);
        div_next = tick ? 8'h00 : div_reg + 8'h01;
        sseg_next = sseg_reg;
        sline_next = sline_reg;
        frame_next = frame_reg;
        if (tick) begin
            sseg_next = sseg_reg + 8'h01;
            if (sseg_reg == LAST_COL) begin
                sseg_next = 8'h00;
                sline_next = sline_reg + 8'h01;
                if (sline_reg >= lines_reg - 8'h01) begin
                    sline_next = 8'h00;
                    frame_next = frame_reg + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            div_reg <= 8'h00;
            sseg_reg <= 8'h00;
            sline_reg <= 8'h00;
            frame_reg <= '0;
        end else begin
            div_reg <= div_next;
            sseg_reg <= sseg_next;
            sline_reg <= sline_next;
            frame_reg <= frame_next;
        end
    end

    always_comb begin
        line_sum = {1'b0, start_reg} + {1'b0, sline_reg};
        disp_line = (line_sum >= LINE_WRAP) ? 8'(line_sum - LINE_WRAP) : line_sum[7:0];
        disp_col = mode_reg[MODE_COL_REV] ? LAST_COL - sseg_reg : sseg_reg;
        disp_idx = mem_index(page_of(disp_line, mode_reg[MODE_GRAY]), disp_col);
    end

    assign pix.pix_valid = tick;
    assign pix.raw_dot = dot_of(mem[disp_idx], disp_line, mode_reg[MODE_GRAY]);
    assign pix.seg_idx = sseg_reg;
    // first scanned line sits on the first common output of the scan order
    assign pix.com_idx = mode_reg[MODE_COM_REV] ? LAST_LINE - sline_reg : sline_reg;
    assign pix.frame = frame_reg;
    assign pix.gray_mode = mode_reg[MODE_GRAY];
    assign pix.invert = mode_reg[MODE_INVERT];
    assign pix.disp_on = mode_reg[MODE_DISP_ON];
    assign pix.all_on = mode_reg[MODE_ALL_ON];
    assign pix.pat1 = gray_reg[3:0];
    assign pix.pat2 = gray_reg[7:4];

    drm_out_latch u_latch (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pix(pix.latch)
    );

    assign host_rdata_out = rdata_reg;
    assign pix_valid_out = pix.lat_valid;
    assign segment_output_out = pix.lat_seg;
    assign common_output_out = pix.lat_com;
    assign level_out = pix.lat_level;
    assign dark_out = pix.lat_dark;
    assign frame_out = frame_reg;
endmodule : drm_top
`default_nettype wire
